// ===== bench/rop_gate_assertions.sv
// checker: port relations of the parameter store and threshold gate
`timescale 1ns/100ps
module rop_gate_assertions
	import rop_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic param_wr,
	input wire logic [4:0] readback_index,
	input wire logic [15:0] parameter_readback,
	input wire logic loop_start,
	input wire logic loop_out_ready,
	input wire logic loop_out_valid,
	input wire logic loop_busy,
	input wire logic reconfig,
	input wire logic rate_switch,
	input wire logic pulse_tick,
	input wire logic clear_filter_state,
	input wire logic settle_busy,
	input wire rop_pkg::rop_mode_t top_level_mode,
	input wire logic dual_period_short_pairs,
	input wire logic dual_period_both_pairs,
	input wire logic window_hamming,
	input wire logic simple_unfold_select,
	input wire logic custom_pattern_processing,
	input wire logic range_norm_enable,
	input wire rop_pkg::rop_gas_t gas_atten,
	input wire logic bin_valid,
	input wire logic signed [15:0] v_high,
	input wire logic signed [15:0] v_low,
	input wire logic signed [15:0] unfold_simple,
	input wire logic result_valid
);
	logic [4:0] up;
	logic [4:0] outs;
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	// -------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------
	// readback is only trusted once the default fill has run
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) up <= 5'h00;
		else if (up != 5'h18) up <= up + 5'h01;
	end
	// words handed back during one loopback test
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) outs <= 5'h00;
		else if (loop_start && !loop_busy) outs <= 5'h00;
		else if (loop_out_valid && loop_out_ready) outs <= outs + 5'h01;
	end
	// -------------------------------------------------------------
	// properties
	// -------------------------------------------------------------
	a_result_lat: assert property (
		reset_n |=> result_valid == $past(bin_valid))
		else $error("result latency");
	a_unfold_diff: assert property (
		reset_n |=> unfold_simple == 16'($past(v_high) - $past(v_low)))
		else $error("simple unfold wrong");
	a_dual_decode: assert property (
		dual_period_short_pairs == (top_level_mode == ROP_MODE_DUAL_SHORT)
		&& dual_period_both_pairs == (top_level_mode == ROP_MODE_DUAL_BOTH))
		else $error("dual period flags wrong");
	a_gas_gate: assert property (
		!range_norm_enable [*3] |-> !gas_atten.active)
		else $error("gas active without range norm");
	a_filter_bits: assert property (
		(up == 5'h18 && readback_index == ROP_W_FILTER && !param_wr) [*2]
		|-> parameter_readback[12:11] ==
		{custom_pattern_processing, simple_unfold_select}
		&& parameter_readback[9] == window_hamming)
		else $error("filter word bits disagree");
	a_mode_word: assert property (
		(up == 5'h18 && readback_index == ROP_W_MODE && !param_wr) [*2]
		|-> (parameter_readback[15:12] == 4'h0) ==
		(top_level_mode == ROP_MODE_PULSE_PAIR)
		&& (parameter_readback[15:12] == 4'h1) ==
		(top_level_mode == ROP_MODE_BATCH_FFT)
		&& (parameter_readback[15:12] == 4'h2) ==
		(top_level_mode == ROP_MODE_RANDOM_PHASE))
		else $error("mode decode wrong");
	a_loop_count: assert property (
		$fell(loop_busy) |-> outs == 5'h10) else $error("loopback count");
	a_loop_enter: assert property (
		loop_start && !loop_busy |=> loop_busy) else $error("loop not busy");
	a_settle_hold: assert property (
		settle_busy && !pulse_tick && !param_wr && !reconfig && !rate_switch
		|=> settle_busy) else $error("settling ended without pulse");
	a_clear_cause: assert property (
		clear_filter_state |-> $past(reconfig) || $past(rate_switch) ||
		$past(param_wr)) else $error("clear without a cause");
endmodule : rop_gate_assertions

bind rop_gate rop_gate_assertions u_rop_gate_assertions (.clock, .reset_n,
	.param_wr, .readback_index, .parameter_readback, .loop_start,
	.loop_out_ready, .loop_out_valid, .loop_busy, .reconfig, .rate_switch,
	.pulse_tick, .clear_filter_state, .settle_busy, .top_level_mode,
	.dual_period_short_pairs, .dual_period_both_pairs, .window_hamming,
	.simple_unfold_select, .custom_pattern_processing, .range_norm_enable,
	.gas_atten, .bin_valid, .v_high, .v_low, .unfold_simple, .result_valid);

// ===== bench/rop_gate_tb.sv
// testbench for the parameter store and threshold gate
`timescale 1ns/100ps
module rop_gate_tb;
	import rop_pkg::*;
	typedef struct packed {
		logic [4:0] idx;
		logic [15:0] val;
	} rop_row_t;
	// defaults after power-up, plus one unmapped index that reads zero
	rop_row_t rows [12] = '{'{ROP_W_SAMPLE, 16'h0019},
		'{ROP_W_SLOPE, 16'h07ae}, '{ROP_W_FLAG_UZ, 16'haaaa},
		'{ROP_W_FLAG_CZ, 16'h8888}, '{ROP_W_FLAG_VEL, 16'hc0c0},
		'{ROP_W_FLAG_WID, 16'hc000}, '{ROP_W_FLAG_ZDR, 16'haaaa},
		'{ROP_W_FILTER, 16'h000a}, '{ROP_W_WAVE, 16'h14b4},
		'{ROP_W_FLAGS, 16'h0017}, '{ROP_W_GAS, 16'h0640},
		'{5'h15, 16'h0000}};
	logic [15:0] sw [4] = '{16'haaaa, 16'hcccc, 16'hf0f0, 16'hff00};
	logic [3:0] md [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h3};
	rop_mode_t me [6] = '{ROP_MODE_PULSE_PAIR, ROP_MODE_BATCH_FFT,
		ROP_MODE_RANDOM_PHASE, ROP_MODE_DUAL_SHORT, ROP_MODE_DUAL_BOTH,
		ROP_MODE_UNKNOWN};
	logic [15:0] gn [5] = '{16'h0640, 16'h2710, 16'h2711, 16'h2ee0, 16'h0000};
	logic [20:0] ge [5] = '{21'h100640, 21'h102710, 21'h10271a,
		21'h107530, 21'h000000};
	logic [15:0] ua = 16'haaaa, cz = 16'h8888, ve = 16'hc0c0, wd = 16'hc000;
	logic clock, reset_n, bin_valid, reconfig, rate_switch, pulse_tick;
	logic param_wr, loop_start, loop_in_valid, loop_out_ready;
	logic loop_out_valid, loop_busy, clear_filter_state, settle_busy, seen;
	logic result_valid, window_hamming, simple_unfold_select;
	logic custom_pattern_processing, range_norm_enable;
	logic dual_period_short_pairs, dual_period_both_pairs;
	logic [4:0] param_index, readback_index;
	logic [15:0] param_data, loop_in_data, loop_out_data, parameter_readback;
	logic [15:0] noise_slope;
	logic signed [15:0] v_high, v_low, unfold_simple;
	logic signed [15:0] differential_gain_offset, depol_receiver_offset;
	rop_bin_t bin_in;
	rop_result_t result;
	rop_gas_t gas_atten;
	rop_mode_t top_level_mode;
	int err_count = 0, checked = 0, c, j;

	rop_gate u_rop_gate (.clock, .reset_n, .param_wr, .param_index,
		.param_data, .readback_index, .parameter_readback, .loop_start,
		.loop_in_valid, .loop_in_data, .loop_out_ready, .loop_out_valid,
		.loop_out_data, .loop_busy, .reconfig, .rate_switch, .pulse_tick,
		.clear_filter_state, .settle_busy, .top_level_mode,
		.dual_period_short_pairs, .dual_period_both_pairs,
		.window_hamming, .simple_unfold_select, .custom_pattern_processing,
		.range_norm_enable, .gas_atten, .noise_slope,
		.differential_gain_offset, .depol_receiver_offset, .bin_valid,
		.bin_in, .v_high, .v_low, .unfold_simple, .result_valid, .result);
	rop_host_model u_rop_host_model (.clock, .param_wr, .param_index,
		.param_data, .loop_start, .loop_in_valid, .loop_in_data,
		.loop_out_ready, .loop_out_valid, .loop_out_data);

	always #20 clock = ~clock;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_of_test
	task automatic rb(input logic [4:0] i, input logic [15:0] e);
		@(posedge clock);
		readback_index <= i;
		repeat (2) @(posedge clock);
		#1;
		chk(parameter_readback, e);
	endtask : rb
	// each bit of the code puts one test just at or just under its bound
	task automatic bin(input logic [3:0] k);
		@(posedge clock);
		bin_valid <= 1'b1;
		bin_in.reflectivity <= k[0] ? 16'h0008 : 16'h0007;
		bin_in.clutter_corr <= k[1] ? 16'hfe70 : 16'hfe6f;
		bin_in.quality <= k[2] ? 8'h80 : 8'h7f;
		bin_in.weather_snr <= k[3] ? 16'h00a0 : 16'h009f;
		@(posedge clock);
		bin_valid <= 1'b0;
		#1;
		chk(result.outcome, k);
		chk(result_valid, 1);
	endtask : bin
	task automatic tick();
		@(posedge clock);
		pulse_tick <= 1'b1;
		@(posedge clock);
		pulse_tick <= 1'b0;
	endtask : tick
	task automatic do_reset();
		reset_n <= 1'b0;
		repeat (3) @(posedge clock);
		reset_n <= 1'b1;
		repeat (25) @(posedge clock);
	endtask : do_reset

	// watchdog: the whole sequence needs under two thousand cycles
	initial begin
		repeat (6000) @(posedge clock);
		err_count++;
		end_of_test();
	end

	initial begin
		clock = 1'b0;
		reset_n = 1'b0;
		{bin_valid, reconfig, rate_switch, pulse_tick} = 4'h0;
		readback_index = 5'h00;
		v_high = 16'h0000;
		v_low = 16'h0000;
		bin_in = '0;
		bin_in.power_db = 16'h4000;
		bin_in.velocity = 16'hfffe;
		bin_in.width = 16'h0003;
		do_reset();
		foreach (rows[i]) rb(rows[i].idx, rows[i].val);
		chk(noise_slope, 16'h01eb);
		chk({differential_gain_offset, depol_receiver_offset}, 0);
		$display("test defaults done");
		u_rop_host_model.write_word(ROP_W_SLOPE, 16'h07ae);
		for (c = 0; c < 16; c++) begin
			bin(c[3:0]);
			chk(result.accept, {ua[c], wd[c], ve[c], cz[c], ua[c]});
		end
		chk(result.log_power, 12'h1eb);
		chk(result.velocity_phys, 32'hffffd698);
		chk(result.width_phys, 32'h00003e1c);
		foreach (sw[i]) begin
			u_rop_host_model.write_word(ROP_W_FLAG_UZ, sw[i]);
			for (c = 0; c < 16; c++) begin
				bin(c[3:0]);
				chk(result.accept[0], sw[i][c]);
			end
		end
		$display("test threshold gate done");
		readback_index <= ROP_W_MODE;
		foreach (md[i]) begin
			u_rop_host_model.write_word(ROP_W_MODE, {md[i], 12'h000});
			@(posedge clock);
			#1;
			chk(top_level_mode, me[i]);
			chk({dual_period_short_pairs, dual_period_both_pairs},
				{md[i] == 4'h4, md[i] == 4'h5});
		end
		u_rop_host_model.write_word(ROP_W_OPTION, 16'h0001);
		foreach (gn[i]) begin
			u_rop_host_model.write_word(ROP_W_GAS, gn[i]);
			repeat (2) @(posedge clock);
			#1;
			chk(gas_atten, ge[i]);
		end
		u_rop_host_model.write_word(ROP_W_GAS, 16'h0640);
		u_rop_host_model.write_word(ROP_W_OPTION, 16'h0000);
		repeat (3) @(posedge clock);
		#1;
		chk({range_norm_enable, gas_atten.active}, 0);
		$display("test mode and gas done");
		readback_index <= ROP_W_FILTER;
		// zeroing on, hamming, simple unfold, custom pattern, three pulses
		u_rop_host_model.write_word(ROP_W_FILTER, 16'h1b03);
		for (j = 0; j < 2; j++) begin
			@(posedge clock);
			reconfig <= (j == 0);
			rate_switch <= (j == 1);
			@(posedge clock);
			{reconfig, rate_switch} <= 2'b00;
			#1;
			seen = clear_filter_state;
			repeat (2) begin
				@(posedge clock);
				#1;
				seen |= clear_filter_state;
			end
			chk(seen, j == 0);
			chk(settle_busy, 1);
			repeat (2) tick();
			#1;
			chk(settle_busy, 1);
			tick();
			@(posedge clock);
			#1;
			chk(settle_busy, 0);
			chk({custom_pattern_processing, simple_unfold_select,
				window_hamming}, {3{j == 0}});
			u_rop_host_model.write_word(ROP_W_FILTER, 16'h0003);
		end
		v_high <= 16'h0064;
		v_low <= 16'hffe2;
		repeat (2) @(posedge clock);
		#1;
		chk(unfold_simple, 16'h0082);
		$display("test settling and unfold done");
		u_rop_host_model.loop_run();
		foreach (u_rop_host_model.got[i])
			chk(u_rop_host_model.got[i], 16'h0001 << i);
		@(posedge clock);
		#1;
		chk(loop_busy, 0);
		$display("test loopback done");
		do_reset();
		rb(ROP_W_FLAG_UZ, 16'haaaa);
		rb(ROP_W_OPTION, 16'h0000);
		$display("test second reset done");
		end_of_test();
	end
endmodule : rop_gate_tb

// ===== bench/rop_host_model.sv
// host side model: parameter writes and the sixteen-word loopback
`timescale 1ns/100ps
module rop_host_model (
	input wire logic clock,
	output logic param_wr,
	output logic [4:0] param_index,
	output logic [15:0] param_data,
	output logic loop_start,
	output logic loop_in_valid,
	output logic [15:0] loop_in_data,
	output logic loop_out_ready,
	input wire logic loop_out_valid,
	input wire logic [15:0] loop_out_data
);
	logic [15:0] got [16];
	initial begin
		param_wr = 1'b0;
		param_index = 5'h00;
		param_data = 16'h0000;
		loop_start = 1'b0;
		loop_in_valid = 1'b0;
		loop_in_data = 16'h0000;
		loop_out_ready = 1'b0;
	end
	// data is inverted after the strobe so a late sample never matches
	task automatic write_word(input logic [4:0] idx, input logic [15:0] val);
		@(posedge clock);
		param_wr <= 1'b1;
		param_index <= idx;
		param_data <= val;
		@(posedge clock);
		param_wr <= 1'b0;
		param_data <= ~val;
	endtask : write_word
	// barber pole in, then drain with ready toggling to stall the reply
	task automatic loop_run();
		int n;
		int k;
		@(posedge clock);
		loop_start <= 1'b1;
		for (n = 0; n < 16; n++) begin
			@(posedge clock);
			loop_start <= 1'b0;
			loop_in_valid <= 1'b1;
			loop_in_data <= 16'h0001 << n;
		end
		@(posedge clock);
		loop_in_valid <= 1'b0;
		loop_in_data <= 16'h7fff;
		k = 0;
		for (n = 0; n < 200 && k < 16; n++) begin
			@(posedge clock);
			if (loop_out_valid && loop_out_ready) begin
				got[k] = loop_out_data;
				k++;
			end
			loop_out_ready <= (k < 16) ? ~loop_out_ready : 1'b0;
		end
	endtask : loop_run
endmodule : rop_host_model

// ===== logic/rop_gate.sv
// file: operating parameter store and per-bin threshold gate
`timescale 1ns/100ps
module rop_gate #(
	parameter int unsigned WORDS = 21
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic param_wr,
	input wire logic [4:0] param_index,
	input wire logic [15:0] param_data,
	input wire logic [4:0] readback_index,
	output logic [15:0] parameter_readback,
	input wire logic loop_start,
	input wire logic loop_in_valid,
	input wire logic [15:0] loop_in_data,
	input wire logic loop_out_ready,
	output logic loop_out_valid,
	output logic [15:0] loop_out_data,
	output logic loop_busy,
	input wire logic reconfig,
	input wire logic rate_switch,
	input wire logic pulse_tick,
	output logic clear_filter_state,
	output logic settle_busy,
	output rop_pkg::rop_mode_t top_level_mode,
	output logic dual_period_short_pairs,
	output logic dual_period_both_pairs,
	output logic window_hamming,
	output logic simple_unfold_select,
	output logic custom_pattern_processing,
	output logic range_norm_enable,
	output rop_pkg::rop_gas_t gas_atten,
	output logic [15:0] noise_slope,
	output logic signed [15:0] differential_gain_offset,
	output logic signed [15:0] depol_receiver_offset,
	input wire logic bin_valid,
	input wire rop_pkg::rop_bin_t bin_in,
	input wire logic signed [15:0] v_high,
	input wire logic signed [15:0] v_low,
	output logic signed [15:0] unfold_simple,
	output logic result_valid,
	output rop_pkg::rop_result_t result
);
	import rop_pkg::*;

	// ----------------------------------------------------------------
	// shadow copies of the parameter words
	// ----------------------------------------------------------------
	logic [15:0] w_option;
	logic [15:0] w_slope;
	logic [15:0] w_log_thr;
	logic [15:0] w_clut_thr;
	logic [15:0] w_qty_thr;
	logic [15:0] w_snr_thr;
	logic [15:0] w_mode;
	logic [15:0] w_filter;
	logic [15:0] w_gas;
	logic [15:0] w_wave;
	logic [15:0] w_flag [5];
	logic [15:0] w_dgo;
	logic [15:0] w_dro;
	logic init_wr;
	logic [4:0] init_idx;
	logic mem_wr;
	logic [4:0] mem_addr;
	logic [15:0] mem_data;

	// default value of each word, used for the power-up fill
	function automatic logic [15:0] rop_default(input logic [4:0] idx);
		unique case (idx)
			ROP_W_SAMPLE: rop_default = ROP_DEF_SAMPLE;
			ROP_W_SLOPE: rop_default = ROP_DEF_SLOPE;
			ROP_W_LOG_THR: rop_default = ROP_DEF_LOG_THR;
			ROP_W_CLUT_THR: rop_default = ROP_DEF_CLUT_THR;
			ROP_W_QTY_THR: rop_default = ROP_DEF_QTY_THR;
			ROP_W_SNR_THR: rop_default = ROP_DEF_SNR_THR;
			ROP_W_CAL_REFL: rop_default = ROP_DEF_CAL_REFL;
			ROP_W_FILTER: rop_default = ROP_DEF_FILTER;
			ROP_W_FLAG_UZ: rop_default = ROP_DEF_FLAG_UZ;
			ROP_W_FLAG_CZ: rop_default = ROP_DEF_FLAG_CZ;
			ROP_W_FLAG_VEL: rop_default = ROP_DEF_FLAG_VEL;
			ROP_W_FLAG_WID: rop_default = ROP_DEF_FLAG_WID;
			ROP_W_GAS: rop_default = ROP_DEF_GAS;
			ROP_W_FLAG_ZDR: rop_default = ROP_DEF_FLAG_ZDR;
			ROP_W_WAVE: rop_default = ROP_DEF_WAVE;
			ROP_W_FLAGS: rop_default = ROP_DEF_FLAGS;
			default: rop_default = ROP_DEF_ZERO;
		endcase
	endfunction : rop_default

	// power-up fill walks every word once so readback shows defaults
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			init_wr <= 1'b1;
			init_idx <= 5'h00;
		end else if (init_wr) begin
			init_idx <= init_idx + 5'h01;
			if (init_idx == 5'(WORDS - 1)) begin
				init_wr <= 1'b0;
			end
		end
	end

	assign mem_wr = init_wr | param_wr;
	assign mem_addr = init_wr ? init_idx : param_index;
	assign mem_data = init_wr ? rop_default(init_idx) : param_data;

	rop_param_mem #(
		.DEPTH(WORDS),
		.WIDTH(16)
	) u_mem (
		.clock(clock),
		.reset_n(reset_n),
		.wr_en(mem_wr),
		.wr_addr(mem_addr),
		.wr_data(mem_data),
		.rd_addr(readback_index),
		.rd_data(parameter_readback)
	);

	// live copies steer the logic; host writes ignored during fill
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			w_option <= ROP_DEF_ZERO;
			w_slope <= ROP_DEF_SLOPE;
			w_log_thr <= ROP_DEF_LOG_THR;
			w_clut_thr <= ROP_DEF_CLUT_THR;
			w_qty_thr <= ROP_DEF_QTY_THR;
			w_snr_thr <= ROP_DEF_SNR_THR;
			w_mode <= ROP_DEF_ZERO;
			w_filter <= ROP_DEF_FILTER;
			w_gas <= ROP_DEF_GAS;
			w_wave <= ROP_DEF_WAVE;
			w_flag[0] <= ROP_DEF_FLAG_UZ;
			w_flag[1] <= ROP_DEF_FLAG_CZ;
			w_flag[2] <= ROP_DEF_FLAG_VEL;
			w_flag[3] <= ROP_DEF_FLAG_WID;
			w_flag[4] <= ROP_DEF_FLAG_ZDR;
			w_dgo <= ROP_DEF_ZERO;
			w_dro <= ROP_DEF_ZERO;
		end else if (param_wr && !init_wr) begin
			unique case (param_index)
				ROP_W_OPTION: w_option <= param_data;
				ROP_W_SLOPE: w_slope <= param_data;
				ROP_W_LOG_THR: w_log_thr <= param_data;
				ROP_W_CLUT_THR: w_clut_thr <= param_data;
				ROP_W_QTY_THR: w_qty_thr <= param_data;
				ROP_W_SNR_THR: w_snr_thr <= param_data;
				ROP_W_MODE: w_mode <= param_data;
				ROP_W_FILTER: w_filter <= param_data;
				ROP_W_GAS: w_gas <= param_data;
				ROP_W_WAVE: w_wave <= param_data;
				ROP_W_FLAG_UZ: w_flag[0] <= param_data;
				ROP_W_FLAG_CZ: w_flag[1] <= param_data;
				ROP_W_FLAG_VEL: w_flag[2] <= param_data;
				ROP_W_FLAG_WID: w_flag[3] <= param_data;
				ROP_W_FLAG_ZDR: w_flag[4] <= param_data;
				ROP_W_DGO: w_dgo <= param_data;
				ROP_W_DRO: w_dro <= param_data;
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// mode and option decoding
	// ----------------------------------------------------------------
	always_comb begin
		unique case (w_mode[ROP_MODE_LSB +: 4])
			4'h0: top_level_mode = ROP_MODE_PULSE_PAIR;
			4'h1: top_level_mode = ROP_MODE_BATCH_FFT;
			4'h2: top_level_mode = ROP_MODE_RANDOM_PHASE;
			4'h4: top_level_mode = ROP_MODE_DUAL_SHORT;
			4'h5: top_level_mode = ROP_MODE_DUAL_BOTH;
			default: top_level_mode = ROP_MODE_UNKNOWN;
		endcase
	end

	// dual period modes alternate short and long trigger periods
	assign dual_period_short_pairs = top_level_mode == ROP_MODE_DUAL_SHORT;
	assign dual_period_both_pairs = top_level_mode == ROP_MODE_DUAL_BOTH;
	assign window_hamming = w_filter[ROP_WIN_LSB];
	assign simple_unfold_select = w_filter[ROP_UNF_BIT];
	assign custom_pattern_processing = w_filter[ROP_PAT_BIT];
	assign range_norm_enable = w_option[ROP_RNV_BIT];
	assign noise_slope = {2'b00, w_slope[15:2]};
	assign differential_gain_offset = w_dgo;
	assign depol_receiver_offset = w_dro;

	// simple unfold: high-rate minus low-rate estimate
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			unfold_simple <= '0;
		end else begin
			unfold_simple <= v_high - v_low;
		end
	end

	// gas rate in 1e-5 dB/km; above knee each count is ten units
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			gas_atten <= '0;
		end else begin
			gas_atten.active <= range_norm_enable && w_gas != 16'h0000;
			if (w_gas <= ROP_GAS_KNEE) begin
				gas_atten.rate <= {4'h0, w_gas};
			end else begin
				gas_atten.rate <= 20'(ROP_GAS_KNEE) +
					20'({4'h0, w_gas - ROP_GAS_KNEE} * 20'h0000a);
			end
		end
	end

	// ----------------------------------------------------------------
	// clutter filter settling
	// ----------------------------------------------------------------
	logic [7:0] settle_count;
	logic settle_req;

	assign settle_req = reconfig || rate_switch ||
		(param_wr && !init_wr);

	// zeroing pulses first, then settling counts pulses
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			clear_filter_state <= 1'b0;
			settle_count <= 8'h00;
			settle_busy <= 1'b0;
		end else if (settle_req) begin
			clear_filter_state <= w_filter[ROP_CLR_BIT];
			settle_count <= w_filter[7:0];
			settle_busy <= w_filter[7:0] != 8'h00;
		end else begin
			clear_filter_state <= 1'b0;
			if (settle_busy && pulse_tick) begin
				settle_count <= settle_count - 8'h01;
				settle_busy <= settle_count != 8'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// loopback test: take sixteen words, then return them in order
	// ----------------------------------------------------------------
	logic [15:0] loop_buf [16];
	logic [4:0] loop_count;
	logic loop_return;

	// capture then replay; pointer reused for both phases
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			loop_busy <= 1'b0;
			loop_return <= 1'b0;
			loop_count <= 5'h00;
		end else if (loop_start && !loop_busy) begin
			loop_busy <= 1'b1;
			loop_return <= 1'b0;
			loop_count <= 5'h00;
		end else if (loop_busy && !loop_return && loop_in_valid) begin
			loop_count <= loop_count + 5'h01;
			if (loop_count == ROP_LOOP_WORDS - 5'h01) begin
				loop_return <= 1'b1;
				loop_count <= 5'h00;
			end
		end else if (loop_return && loop_out_ready) begin
			loop_count <= loop_count + 5'h01;
			if (loop_count == ROP_LOOP_WORDS - 5'h01) begin
				loop_return <= 1'b0;
				loop_busy <= 1'b0;
			end
		end
	end

	// storage of the received words
	always_ff @(posedge clock) begin
		if (loop_busy && !loop_return && loop_in_valid) begin
			loop_buf[loop_count[3:0]] <= loop_in_data;
		end
	end

	assign loop_out_valid = loop_return;
	assign loop_out_data = loop_return ? loop_buf[loop_count[3:0]] : '0;

	// ----------------------------------------------------------------
	// per-bin threshold tests, one pipeline stage
	// ----------------------------------------------------------------
	logic [3:0] outcome;
	logic [23:0] scaled;

	// a failing test weighs zero; passing adds 1, 2, 4 or 8
	always_comb begin
		outcome[0] = bin_in.reflectivity >= w_log_thr;
		outcome[1] = bin_in.clutter_corr >= $signed(w_clut_thr);
		outcome[2] = bin_in.quality >= w_qty_thr[7:0];
		outcome[3] = bin_in.weather_snr >= w_snr_thr;
		scaled = 24'((32'(bin_in.power_db) * 32'(w_slope)) >> 16);
	end

	// results registered; throughput one bin a clock
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			result_valid <= 1'b0;
			result <= '0;
		end else begin
			result_valid <= bin_valid;
			result.outcome <= outcome;
			for (int p = 0; p < 5; p++) begin
				result.accept[p] <= w_flag[p][outcome];
			end
			result.log_power <= scaled[23:12] != 12'h000 ? 12'hfff :
				scaled[11:0];
			// wavelength in units of 1e-3 cm times nyquist units
			result.velocity_phys <= 32'($signed(bin_in.velocity) *
				$signed({1'b0, w_wave}));
			result.width_phys <= 32'(bin_in.width) * 32'(w_wave);
		end
	end
endmodule : rop_gate

// ===== logic/rop_param_mem.sv
// file: small register memory holding the parameter words
`timescale 1ns/100ps
module rop_param_mem #(
	parameter int unsigned DEPTH = 21,
	parameter int unsigned WIDTH = 16
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic wr_en,
	input wire logic [4:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [4:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	import rop_pkg::*;

	logic [WIDTH-1:0] mem [DEPTH];

	// read data registered so the host sees stable words
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rd_data <= '0;
		end else if (rd_addr < 5'(DEPTH)) begin
			rd_data <= mem[rd_addr];
		end else begin
			rd_data <= '0;
		end
	end

	// write port; storage needs no reset, the top loads defaults
	always_ff @(posedge clock) begin
		if (wr_en && wr_addr < 5'(DEPTH)) begin
			mem[wr_addr] <= wr_data;
		end
	end
endmodule : rop_param_mem

// ===== logic/rop_pkg.sv
// package: parameter word layout, defaults and per-bin data carriers
package rop_pkg;
	// ----------------------------------------------------------------
	// parameter word indices
	// ----------------------------------------------------------------
	localparam int unsigned ROP_WORD_CNT = 21;
	localparam logic [4:0] ROP_W_SAMPLE = 5'h01;
	localparam logic [4:0] ROP_W_OPTION = 5'h02;
	localparam logic [4:0] ROP_W_SLOPE = 5'h03;
	localparam logic [4:0] ROP_W_LOG_THR = 5'h04;
	localparam logic [4:0] ROP_W_CLUT_THR = 5'h05;
	localparam logic [4:0] ROP_W_QTY_THR = 5'h06;
	localparam logic [4:0] ROP_W_SNR_THR = 5'h07;
	localparam logic [4:0] ROP_W_CAL_REFL = 5'h08;
	localparam logic [4:0] ROP_W_MODE = 5'h09;
	localparam logic [4:0] ROP_W_FILTER = 5'h0a;
	localparam logic [4:0] ROP_W_FLAG_UZ = 5'h0b;
	localparam logic [4:0] ROP_W_FLAG_CZ = 5'h0c;
	localparam logic [4:0] ROP_W_FLAG_VEL = 5'h0d;
	localparam logic [4:0] ROP_W_FLAG_WID = 5'h0e;
	localparam logic [4:0] ROP_W_GAS = 5'h0f;
	localparam logic [4:0] ROP_W_FLAG_ZDR = 5'h10;
	localparam logic [4:0] ROP_W_DGO = 5'h11;
	localparam logic [4:0] ROP_W_DRO = 5'h12;
	localparam logic [4:0] ROP_W_WAVE = 5'h13;
	localparam logic [4:0] ROP_W_FLAGS = 5'h14;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int unsigned ROP_RNV_BIT = 0;
	localparam int unsigned ROP_CLR_BIT = 8;
	localparam int unsigned ROP_WIN_LSB = 9;
	localparam int unsigned ROP_UNF_BIT = 11;
	localparam int unsigned ROP_PAT_BIT = 12;
	localparam int unsigned ROP_MODE_LSB = 12;

	// ----------------------------------------------------------------
	// power-up values
	// ----------------------------------------------------------------
	localparam logic [15:0] ROP_DEF_SAMPLE = 16'h0019;
	localparam logic [15:0] ROP_DEF_FLAGS = 16'h0017;
	localparam logic [15:0] ROP_DEF_SLOPE = 16'h07ae;
	localparam logic [15:0] ROP_DEF_LOG_THR = 16'h0008;
	localparam logic [15:0] ROP_DEF_CLUT_THR = 16'hfe70;
	localparam logic [15:0] ROP_DEF_QTY_THR = 16'h0080;
	localparam logic [15:0] ROP_DEF_SNR_THR = 16'h00a0;
	localparam logic [15:0] ROP_DEF_CAL_REFL = 16'hfea0;
	localparam logic [15:0] ROP_DEF_GAS = 16'h0640;
	localparam logic [15:0] ROP_DEF_ZERO = 16'h0000;
	localparam logic [15:0] ROP_DEF_WAVE = 16'h14b4;
	localparam logic [15:0] ROP_DEF_FILTER = 16'h000a;
	localparam logic [15:0] ROP_DEF_FLAG_UZ = 16'haaaa;
	localparam logic [15:0] ROP_DEF_FLAG_CZ = 16'h8888;
	localparam logic [15:0] ROP_DEF_FLAG_VEL = 16'hc0c0;
	localparam logic [15:0] ROP_DEF_FLAG_WID = 16'hc000;
	localparam logic [15:0] ROP_DEF_FLAG_ZDR = 16'haaaa;

	// ----------------------------------------------------------------
	// gas attenuation break point and loopback length
	// ----------------------------------------------------------------
	localparam logic [15:0] ROP_GAS_KNEE = 16'h2710;
	localparam logic [4:0] ROP_LOOP_WORDS = 5'h10;

	// top-level processing modes
	typedef enum logic [2:0] {
		ROP_MODE_PULSE_PAIR,
		ROP_MODE_BATCH_FFT,
		ROP_MODE_RANDOM_PHASE,
		ROP_MODE_DUAL_SHORT,
		ROP_MODE_DUAL_BOTH,
		ROP_MODE_UNKNOWN
	} rop_mode_t;

	// one range bin's test inputs
	typedef struct packed {
		logic [15:0] reflectivity;
		logic signed [15:0] clutter_corr;
		logic [7:0] quality;
		logic [15:0] weather_snr;
		logic [15:0] power_db;
		logic signed [15:0] velocity;
		logic [15:0] width;
	} rop_bin_t;

	// one range bin's results
	typedef struct packed {
		logic [3:0] outcome;
		logic [4:0] accept;
		logic [11:0] log_power;
		logic [31:0] velocity_phys;
		logic [31:0] width_phys;
	} rop_result_t;

	// gas attenuation in units of 1e-5 dB/km
	typedef struct packed {
		logic active;
		logic [19:0] rate;
	} rop_gas_t;
endpackage : rop_pkg
